// ---- design/spm_buf2.sv ----
// Two-entry valid/ready buffer carrying received words to the host side.
module spm_buf2 (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire spm_pkg::spm_word_t in_word,
	output logic out_valid,
	input wire logic out_ready,
	output spm_pkg::spm_word_t out_word
);
	spm_pkg::spm_word_t mem_r [2];
	spm_pkg::spm_word_t mem_nxt [2];
	logic [1:0] cnt_r, cnt_nxt;
	logic rd_r, rd_nxt, wr_r, wr_nxt;
	logic push, pop;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_word = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = in_word;
			wr_nxt = ~wr_r;
		end
		if (pop)
			rd_nxt = ~rd_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 2'h1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 2'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			cnt_r <= 2'h0;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
		end else begin
			mem_r <= mem_nxt;
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
		end
	end
endmodule

// ---- design/spm_serial_port.sv ----
// Serial port core covering synchronous mode 0 and asynchronous modes 1, 2.
module spm_serial_port (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] serial_mode,
	input wire logic mode_aux_select,
	input wire logic baud_double_select,
	input wire logic rx_enable,
	input wire logic timer1_overflow,
	input wire logic tx_ninth_bit,
	input wire logic buf_wr,
	input wire logic [7:0] buf_wdata,
	input wire logic buf_rd,
	output logic [7:0] serial_buffer,
	output logic rx_ninth_bit,
	input wire logic tx_done_clr,
	input wire logic rx_done_clr,
	output logic tx_done_flag,
	output logic rx_done_flag,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd_out
);
	logic rx_s1_r, rx_s2_r, rx_prev_r;
	logic [5:0] pre_r, pre_nxt;
	logic tick;
	logic [3:0] t16_r, t16_nxt, r16_r, r16_nxt;
	logic [10:0] tsh_r, tsh_nxt;
	logic [3:0] tcnt_r, tcnt_nxt;
	logic tbusy_r, tbusy_nxt, tpend_r, tpend_nxt;
	logic txd_r, txd_nxt, rxo_r, rxo_nxt, oe_r, oe_nxt;
	logic tdone_r, tdone_nxt, rdone_r, rdone_nxt;
	spm_pkg::spm_rx_state_t rst_r, rst_nxt;
	logic [9:0] rsh_r, rsh_nxt;
	logic [3:0] rcnt_r, rcnt_nxt;
	logic [2:0] vote_r, vote_nxt;
	logic [3:0] ph_r, ph_nxt;
	logic m0_rx_r, m0_rx_nxt;
	logic push, push_ready, out_valid;
	spm_pkg::spm_word_t push_word, out_word;
	logic voted;
	logic [3:0] fall_at, low_len, per, frame_len;

	spm_buf2 u_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(push),
		.in_ready(push_ready),
		.in_word(push_word),
		.out_valid(out_valid),
		.out_ready(buf_rd),
		.out_word(out_word)
	);

	// Words wait in the buffer; the visible copy is the oldest entry.
	assign serial_buffer = out_word.data;
	assign rx_ninth_bit = out_word.ninth;
	assign tx_done_flag = tdone_r;
	assign rx_done_flag = rdone_r;
	assign txd_out = txd_r;
	assign rxd_out = rxo_r;
	assign rxd_oe = oe_r;
	assign voted = (vote_r[0] & vote_r[1]) | (vote_r[0] & vote_r[2])
		| (vote_r[1] & vote_r[2]);

	always_comb begin
		fall_at = mode_aux_select ? spm_pkg::M0_FAST_FALL
			: spm_pkg::M0_SLOW_FALL;
		low_len = mode_aux_select ? spm_pkg::M0_FAST_LOW
			: spm_pkg::M0_SLOW_LOW;
		per = mode_aux_select ? 4'(spm_pkg::M0_FAST_DIV)
			: 4'(spm_pkg::M0_SLOW_DIV);
		frame_len = (serial_mode == spm_pkg::MODE_ASYNC11)
			? spm_pkg::FRAME11_BITS : spm_pkg::FRAME10_BITS;
	end

	// Sixteen-times bit-rate tick for the asynchronous modes.
	always_comb begin
		pre_nxt = pre_r;
		tick = 1'b0;
		if (serial_mode == spm_pkg::MODE_ASYNC11) begin
			pre_nxt = pre_r + 6'h01;
			if (pre_nxt >= (baud_double_select ? spm_pkg::M2_TICK_FAST
				: spm_pkg::M2_TICK_SLOW)) begin
				pre_nxt = 6'h00;
				tick = 1'b1;
			end
		end else if (timer1_overflow) begin
			pre_nxt = pre_r + 6'h01;
			if (pre_nxt >= (baud_double_select ? 6'h01 : 6'h02)) begin
				pre_nxt = 6'h00;
				tick = 1'b1;
			end
		end
	end

	// Transmitter and mode 0 shift engine share the shift register.
	always_comb begin
		t16_nxt = t16_r;
		tsh_nxt = tsh_r;
		tcnt_nxt = tcnt_r;
		tbusy_nxt = tbusy_r;
		tpend_nxt = tpend_r;
		txd_nxt = txd_r;
		rxo_nxt = rxo_r;
		oe_nxt = oe_r;
		ph_nxt = ph_r;
		m0_rx_nxt = m0_rx_r;
		tdone_nxt = tdone_r & ~tx_done_clr;
		if (tick)
			t16_nxt = t16_r + 4'h1;
		if (serial_mode == spm_pkg::MODE_SYNC) begin
			if (!tbusy_r && buf_wr) begin
				tsh_nxt = {3'h0, buf_wdata};
				tbusy_nxt = 1'b1;
				m0_rx_nxt = 1'b0;
				tcnt_nxt = 4'h0;
				ph_nxt = 4'h0;
				oe_nxt = 1'b1;
				rxo_nxt = buf_wdata[0];
			end else if (!tbusy_r && rx_enable && !rdone_r
				&& rst_r == spm_pkg::SPM_RX_IDLE) begin
				tbusy_nxt = 1'b1;
				m0_rx_nxt = 1'b1;
				tcnt_nxt = 4'h0;
				ph_nxt = 4'h0;
				oe_nxt = 1'b0;
			end else if (tbusy_r) begin
				ph_nxt = ph_r + 4'h1;
				if (ph_nxt == fall_at)
					txd_nxt = 1'b0;
				if (ph_nxt == fall_at + low_len)
					txd_nxt = 1'b1;
				if (ph_nxt == per) begin
					ph_nxt = 4'h0;
					tcnt_nxt = tcnt_r + 4'h1;
					tsh_nxt = {1'b0, tsh_r[10:1]};
					rxo_nxt = tsh_r[1];
					if (tcnt_r == 4'h7) begin
						tbusy_nxt = 1'b0;
						oe_nxt = 1'b0;
						rxo_nxt = 1'b1;
						if (!m0_rx_r)
							tdone_nxt = 1'b1;
					end
				end
			end
		end else begin
			oe_nxt = 1'b0;
			if (buf_wr && !tbusy_r && !tpend_r) begin
				tpend_nxt = 1'b1;
				tsh_nxt = {1'b1, tx_ninth_bit, buf_wdata, 1'b0};
				if (serial_mode == spm_pkg::MODE_ASYNC10)
					tsh_nxt = {2'b11, buf_wdata, 1'b0};
			end
			// Done comes one clock after the stop bit is put out; the stop
			// bit still lasts a full bit, since a new frame waits a rollover.
			if (tbusy_r && tcnt_r == frame_len) begin
				tbusy_nxt = 1'b0;
				tdone_nxt = 1'b1;
			end else if (tick && t16_r == 4'hf) begin
				if (tpend_r) begin
					tpend_nxt = 1'b0;
					tbusy_nxt = 1'b1;
					tcnt_nxt = 4'h1;
					txd_nxt = tsh_r[0];
					tsh_nxt = {1'b1, tsh_r[10:1]};
				end else if (tbusy_r) begin
					txd_nxt = tsh_r[0];
					tsh_nxt = {1'b1, tsh_r[10:1]};
					tcnt_nxt = tcnt_r + 4'h1;
				end
			end
		end
	end

	// Receiver: async bit sampler and mode 0 rising-edge capture.
	always_comb begin
		rst_nxt = rst_r;
		rsh_nxt = rsh_r;
		rcnt_nxt = rcnt_r;
		vote_nxt = vote_r;
		r16_nxt = r16_r;
		rdone_nxt = rdone_r & ~rx_done_clr;
		push = 1'b0;
		push_word = '0;
		if (serial_mode == spm_pkg::MODE_SYNC) begin
			rst_nxt = spm_pkg::SPM_RX_IDLE;
			// The pin reaches rx_s2_r two clocks late, so the bit present one clock
			// before the rising shift clock is taken one clock after that edge.
			if (tbusy_r && m0_rx_r && ph_r == fall_at + low_len) begin
				rsh_nxt = {rx_s2_r, rsh_r[9:1]};
				if (tcnt_r == 4'h7 && push_ready) begin
					push = 1'b1;
					push_word.data = {rx_s2_r, rsh_r[9:3]};
					push_word.ninth = 1'b0;
					rdone_nxt = 1'b1;
				end
			end
		end else begin
			unique case (rst_r)
			spm_pkg::SPM_RX_IDLE: begin
				if (rx_enable && rx_prev_r && !rx_s2_r) begin
					rst_nxt = spm_pkg::SPM_RX_BITS;
					r16_nxt = 4'h0;
					rcnt_nxt = 4'h0;
				end
			end
			spm_pkg::SPM_RX_BITS: begin
				if (tick) begin
					r16_nxt = r16_r + 4'h1;
					if (r16_r == spm_pkg::SAMPLE_A)
						vote_nxt[0] = rx_s2_r;
					if (r16_r == spm_pkg::SAMPLE_B)
						vote_nxt[1] = rx_s2_r;
					if (r16_r == spm_pkg::SAMPLE_C) begin
						vote_nxt[2] = rx_s2_r;
						rst_nxt = spm_pkg::SPM_RX_SYNC;
					end
				end
			end
			spm_pkg::SPM_RX_SYNC: begin
				// A tick landing here still counts, so bit timing cannot slip.
				if (tick)
					r16_nxt = r16_r + 4'h1;
				rst_nxt = spm_pkg::SPM_RX_BITS;
				rcnt_nxt = rcnt_r + 4'h1;
				rsh_nxt = {voted, rsh_r[9:1]};
				if (rcnt_r == 4'h0 && voted)
					rst_nxt = spm_pkg::SPM_RX_IDLE;
				else if (rcnt_r == frame_len - 4'h1) begin
					rst_nxt = spm_pkg::SPM_RX_HALT;
					if (!rdone_r && push_ready
						&& (!mode_aux_select || voted)) begin
						push = 1'b1;
						rdone_nxt = 1'b1;
						if (serial_mode == spm_pkg::MODE_ASYNC11) begin
							push_word.data = rsh_r[8:1];
							push_word.ninth = rsh_r[9];
						end else begin
							push_word.data = rsh_r[9:2];
							push_word.ninth = voted;
						end
					end
				end
			end
			spm_pkg::SPM_RX_HALT: rst_nxt = spm_pkg::SPM_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_prev_r <= 1'b1;
			pre_r <= 6'h00;
			t16_r <= 4'h0;
			r16_r <= 4'h0;
			tsh_r <= 11'h7ff;
			tcnt_r <= 4'h0;
			tbusy_r <= 1'b0;
			tpend_r <= 1'b0;
			txd_r <= 1'b1;
			rxo_r <= 1'b1;
			oe_r <= 1'b0;
			tdone_r <= 1'b0;
			rdone_r <= 1'b0;
			rst_r <= spm_pkg::SPM_RX_IDLE;
			rsh_r <= {1'b0, spm_pkg::RX_BUF_RESET};
			rcnt_r <= 4'h0;
			vote_r <= 3'h7;
			ph_r <= 4'h0;
			m0_rx_r <= 1'b0;
		end else begin
			rx_s1_r <= rxd_in;
			rx_s2_r <= rx_s1_r;
			rx_prev_r <= rx_s2_r;
			pre_r <= pre_nxt;
			t16_r <= t16_nxt;
			r16_r <= r16_nxt;
			tsh_r <= tsh_nxt;
			tcnt_r <= tcnt_nxt;
			tbusy_r <= tbusy_nxt;
			tpend_r <= tpend_nxt;
			txd_r <= txd_nxt;
			rxo_r <= rxo_nxt;
			oe_r <= oe_nxt;
			tdone_r <= tdone_nxt;
			rdone_r <= rdone_nxt;
			rst_r <= rst_nxt;
			rsh_r <= rsh_nxt;
			rcnt_r <= rcnt_nxt;
			vote_r <= vote_nxt;
			ph_r <= ph_nxt;
			m0_rx_r <= m0_rx_nxt;
		end
	end
endmodule

// ---- include/spm_pkg.sv ----
// Package of constants and carrier types for the serial port, modes 0 to 2.
// Contract
// - One buffer address: writes go to transmit, reads come from receive.
// - Mode 0 moves 8 bits LSB first on rx line, clock on tx line.
// - Mode 0 shift rate is clock/12 with aux select 0, clock/4 with 1.
// - Fast mode 0: data 1 clock before clock falls, low for 2.
// - Slow mode 0: data 3 clocks before clock falls, low for 6.
// - Mode 0 transmit starts on buffer write; done flag set after last bit.
// - Mode 0 receive while enabled and rx flag clear; set after 8th rise.
// - Mode 1 frame: start 0, 8 data LSB first, stop 1; stop stored.
// - Mode 1 bit rate is timer 1 overflow rate divided by 16 or 32.
// - Async transmit bits change after divide-by-16 rollovers, not at write.
// - Transmit done set after stop bit: 10th rollover mode 1, 11th mode 2.
// - Async receiver samples at 16x; falling edge resets divide-by-16 counter.
// - Bit value is 2-of-3 majority of samples at states 8, 9, 10; code samples at counter states 7, 8, 9 (SAMPLE_A to SAMPLE_C).
// - A start bit voted as 1 aborts reception and rearms edge search.
// - Load buffer and ninth bit only if rx flag 0 and (aux 0 or stop 1).
// - After mid stop bit, receiver looks again for a falling edge.
// - Mode 2 frame: start 0, 8 data, ninth bit from tx field, stop 1.
// - Mode 2 bit rate is clock/32 or clock/64 by baud double select.
// - Mode 2 stores received ninth bit and eight data bits on acceptance.
package spm_pkg;
	localparam logic [1:0] MODE_SYNC = 2'h0;
	localparam logic [1:0] MODE_ASYNC10 = 2'h1;
	localparam logic [1:0] MODE_ASYNC11 = 2'h2;
	localparam int M0_SLOW_DIV = 12;
	localparam int M0_FAST_DIV = 4;
	localparam logic [3:0] M0_SLOW_FALL = 4'h3;
	localparam logic [3:0] M0_FAST_FALL = 4'h1;
	localparam logic [3:0] M0_SLOW_LOW = 4'h6;
	localparam logic [3:0] M0_FAST_LOW = 4'h2;
	localparam logic [5:0] M2_TICK_FAST = 6'h02;
	localparam logic [5:0] M2_TICK_SLOW = 6'h04;
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_B = 4'h8;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] FRAME10_BITS = 4'ha;
	localparam logic [3:0] FRAME11_BITS = 4'hb;
	localparam logic [8:0] RX_BUF_RESET = 9'h000;
	typedef struct packed {
		logic [7:0] data;
		logic ninth;
	} spm_word_t;
	typedef enum logic [1:0] {
		SPM_RX_IDLE = 2'b00,
		SPM_RX_BITS = 2'b01,
		SPM_RX_SYNC = 2'b10,
		SPM_RX_HALT = 2'b11
	} spm_rx_state_t;
endpackage

// ---- tb/spm_assertions.sv ----
// Checker of serial port timing and flag behaviour at the top ports.
module spm_assertions (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] serial_mode,
	input wire logic mode_aux_select,
	input wire logic baud_double_select,
	input wire logic rx_enable,
	input wire logic tx_done_clr,
	input wire logic rx_done_clr,
	input wire logic tx_done_flag,
	input wire logic rx_done_flag,
	input wire logic rxd_oe,
	input wire logic txd_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic m0 = serial_mode == 2'h0;
	wire logic fa = m0 && mode_aux_select;
	wire logic sl = m0 && !mode_aux_select;
	property p_oe;
		serial_mode != 2'h0 && $past(serial_mode) != 2'h0 |-> !rxd_oe;
	endproperty
	a_oe: assert property (p_oe) else $error("data pin driven");
	property p_fa_lead;
		fa && $rose(rxd_oe) |-> ##1 $fell(txd_out);
	endproperty
	a_fa_lead: assert property (p_fa_lead) else $error("fast lead");
	property p_sl_lead;
		sl && $rose(rxd_oe) |-> ##3 $fell(txd_out);
	endproperty
	a_sl_lead: assert property (p_sl_lead) else $error("slow lead");
	property p_fa_low;
		fa && $fell(txd_out) |-> !txd_out[*2] ##1 txd_out;
	endproperty
	a_fa_low: assert property (p_fa_low) else $error("fast low");
	property p_sl_low;
		sl && $fell(txd_out) |-> !txd_out[*6] ##1 txd_out;
	endproperty
	a_sl_low: assert property (p_sl_low) else $error("slow low");
	property p_tx_hold;
		tx_done_flag && !tx_done_clr |=> tx_done_flag;
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx flag");
	property p_rx_hold;
		rx_done_flag && !rx_done_clr |=> rx_done_flag;
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("rx flag");
	property p_m2_bit;
		serial_mode == 2'h2 && baud_double_select && $fell(txd_out)
			|-> !txd_out[*8];
	endproperty
	a_m2_bit: assert property (p_m2_bit) else $error("bit short");
	property p_stop;
		$rose(tx_done_flag) && !m0 |-> txd_out;
	endproperty
	a_stop: assert property (p_stop) else $error("no stop");
	property p_rx_en;
		$rose(rx_done_flag) |-> $past(rx_enable);
	endproperty
	a_rx_en: assert property (p_rx_en) else $error("rx off");
endmodule

bind spm_serial_port spm_assertions u_spm_assertions (.sys_clk, .rst,
	.serial_mode, .mode_aux_select, .baud_double_select, .rx_enable,
	.tx_done_clr, .rx_done_clr, .tx_done_flag, .rx_done_flag, .rxd_oe,
	.txd_out);

// ---- tb/spm_peer.sv ----
// Far-side peer: async frame sender and mode 0 shift register.
module spm_peer (
	input wire logic sys_clk,
	input wire logic m0,
	input wire logic txd_out,
	input wire logic rxd_out,
	input wire logic rxd_oe,
	output logic rxd_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic drv = 1'b1;
	logic [7:0] sh = 8'h00;
	int n = 0;
	// When the core releases the line it reads the peer's drv value, which rests high.
	assign rxd_in = rxd_oe ? rxd_out : drv;
	task automatic send(input logic [10:0] f, input int nb, input int p);
		for (int i = 0; i < nb; i++) begin
			drv = f[i];
			repeat (p) @(negedge sys_clk);
		end
		drv = 1'b1;
	endtask
	task automatic load(input logic [7:0] d);
		sh = d;
		n = 8;
	endtask
	// A new bit on each falling shift clock keeps it steady at the rise.
	always @(negedge txd_out) begin
		if (m0 && n > 0) begin
			drv <= sh[0];
			sh <= sh >> 1;
			n <= n - 1;
		end
	end
	// Hold time ends a little after the eighth rise.
	always @(posedge txd_out) begin
		if (m0 && n == 0)
			drv <= #100 1'b1;
	end
endmodule

// ---- tb/spm_serial_port_tb_top.sv ----
// Self-checking bench for the serial port in modes 0 to 2.
module spm_serial_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] serial_mode = 2'h0;
	logic mode_aux_select = 1'b0;
	logic baud_double_select = 1'b0;
	logic rx_enable = 1'b0;
	logic timer1_overflow = 1'b0;
	logic tx_ninth_bit = 1'b0;
	logic buf_wr = 1'b0;
	logic [7:0] buf_wdata = 8'h00;
	logic buf_rd = 1'b0;
	logic tx_done_clr = 1'b0;
	logic rx_done_clr = 1'b0;
	logic [7:0] serial_buffer;
	logic rx_ninth_bit, tx_done_flag, rx_done_flag;
	logic rxd_in, rxd_out, rxd_oe, txd_out;
	logic [1:0] tc = 2'h0;
	logic tq = 1'b1;
	logic [7:0] m0w = 8'h00;
	logic [10:0] aw;
	logic [8:0] rw;
	int m0n = 0;
	int fails = 0;
	int cmp_count = 0;
	int bp = 32;
	int nb = 11;
	logic [10:0] exp_tx[$];
	logic [8:0] exp_rx[$];
	spm_serial_port u_spm_serial_port (.sys_clk, .rst, .serial_mode,
		.mode_aux_select, .baud_double_select, .rx_enable, .timer1_overflow,
		.tx_ninth_bit, .buf_wr, .buf_wdata, .buf_rd, .serial_buffer,
		.rx_ninth_bit, .tx_done_clr, .rx_done_clr, .tx_done_flag,
		.rx_done_flag, .rxd_in, .rxd_out, .rxd_oe, .txd_out);
	spm_peer u_spm_peer (.sys_clk, .m0(serial_mode == 2'h0), .txd_out,
		.rxd_out, .rxd_oe, .rxd_in);
	always #12.5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		tc <= tc + 2'h1;
		timer1_overflow <= &tc;
	end
	assign rw = {serial_buffer, serial_mode == 2'h0 ? 1'b0 : rx_ninth_bit};
	task chk(input logic [10:0] s, input logic [10:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task results;
		$display("fails=%0d cmp_count=%0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function logic [10:0] frm(input logic [7:0] d, input logic n9);
		return serial_mode[1] ? {1'b1, n9, d, 1'b0} : {2'h3, d, 1'b0};
	endfunction
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
		@(negedge sys_clk);
	endtask
	task rate(input logic [1:0] m, input logic b);
		serial_mode = m;
		baud_double_select = b;
		bp = (m[1] ? 32 : 64) * (b ? 1 : 2);
		nb = m[1] ? 11 : 10;
	endtask
	task wf(input bit r);
		for (int i = 0; i < 5000; i++) begin
			if ((r ? rx_done_flag : tx_done_flag) === 1'b1)
				break;
			@(negedge sys_clk);
		end
	endtask
	task tx(input logic [7:0] d, input logic n9);
		exp_tx.push_back(serial_mode == 2'h0 ? {3'h7, d} : frm(d, n9));
		buf_wdata = d;
		tx_ninth_bit = n9;
		buf_wr = 1'b1;
		@(negedge sys_clk);
		buf_wr = 1'b0;
		if (serial_mode != 2'h0)
			chk(txd_out, 1'b1);
		wf(0);
		chk(tx_done_flag, 1'b1);
		pulse(tx_done_clr);
		chk(tx_done_flag, 1'b0);
		repeat (bp) @(negedge sys_clk);
	endtask
	task rx(input logic [7:0] d, input logic n9, input logic ef, push);
		u_spm_peer.send(frm(d, n9), nb, bp);
		repeat (8) @(negedge sys_clk);
		chk(rx_done_flag, ef);
		if (push)
			exp_rx.push_back({d, serial_mode[1] ? n9 : 1'b1});
	endtask
	// Sampled after the bench's own negedge updates have landed.
	always @(negedge sys_clk) begin
		#1;
		tq <= txd_out;
		if (rxd_oe && tq && !txd_out) begin
			m0w = {rxd_out, m0w[7:1]};
			m0n++;
			if (m0n == 8) begin
				m0n = 0;
				chk({3'h7, m0w}, exp_tx.pop_front());
			end
		end
		if (buf_rd)
			chk(rw, exp_rx.pop_front());
	end
	initial forever begin
		@(negedge txd_out);
		if (serial_mode != 2'h0) begin
			aw = 11'h7ff;
			repeat (bp / 2) @(negedge sys_clk);
			for (int i = 0; i < nb; i++) begin
				if (i > 0)
					repeat (bp) @(negedge sys_clk);
				aw[i] = txd_out;
			end
			chk(aw, exp_tx.pop_front());
		end
	end
	initial begin
		#(60000 * 25);
		fails++;
		results();
	end
	initial begin
		logic [7:0] d;
		void'($urandom(14349));
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		for (int k = 0; k < 2; k++) begin
			mode_aux_select = k[0];
			tx(8'($urandom), 1'b0);
		end
		d = 8'($urandom);
		u_spm_peer.load(d);
		exp_rx.push_back({d, 1'b0});
		rx_enable = 1'b1;
		wf(1);
		rx_enable = 1'b0;
		chk(rx_done_flag, 1'b1);
		pulse(rx_done_clr);
		pulse(buf_rd);
		for (int k = 0; k < 4; k++) begin
			rate(k[1] ? 2'h2 : 2'h1, k[0]);
			tx(8'($urandom), 1'($urandom));
		end
		rate(2'h2, 1'b1);
		mode_aux_select = 1'b0;
		rx_enable = 1'b1;
		// A short low pulse is a false start and must be dropped.
		u_spm_peer.send(11'h000, 1, 4);
		repeat (bp) @(negedge sys_clk);
		rx(8'($urandom), 1'b0, 1'b1, 1'b1);
		rx(8'($urandom), 1'b1, 1'b1, 1'b0);
		pulse(rx_done_clr);
		rx(8'($urandom), 1'b1, 1'b1, 1'b1);
		pulse(rx_done_clr);
		rx(8'($urandom), 1'b0, 1'b0, 1'b0);
		pulse(buf_rd);
		pulse(buf_rd);
		mode_aux_select = 1'b1;
		// With aux set, a frame whose stop bit is 0 must be dropped.
		u_spm_peer.send({2'b00, 8'($urandom), 1'b0}, nb, bp);
		repeat (8) @(negedge sys_clk);
		chk(rx_done_flag, 1'b0);
		rx(8'($urandom), 1'b0, 1'b1, 1'b1);
		pulse(rx_done_clr);
		pulse(buf_rd);
		rate(2'h1, 1'b1);
		rx(8'($urandom), 1'b0, 1'b1, 1'b1);
		pulse(rx_done_clr);
		pulse(buf_rd);
		results();
	end
endmodule
